// ---- rtl/orm_pkg.sv ----
// Constants and encodings for the OR / move-constant execute slice
// Notes on behaviour
// RULE1: Move-constant runs on logic, shift or data unit, writes in first execute stage.
// RULE2: Move-constant variants have zero delay slots; next instruction sees value.
// RULE3: OR gives bitwise inclusive OR of both sources as 32-bit result.
// RULE4: Short signed immediate first operand is sign-extended to 32 bits.
// RULE5: OR accepted on data, logic and shift units, register and immediate forms.
// RULE6: OR opfields: logic 1111111/1111110, shift 011011/011010, data 0001/0011.
// RULE7: OR is single cycle: read and write in first execute stage.
// RULE8: Move-constant sign-extends: 16-bit on shift unit, 5-bit on logic/data.
// RULE9: Low-half move-constant behaves exactly like plain move-constant.
// RULE10: False predicate makes the instruction a no-operation; destination kept.
package orm_pkg;

    // ****************************************************************
    // Instruction word fields
    // ****************************************************************
    localparam int CREG_HI = 31;
    localparam int CREG_LO = 29;
    localparam int ZBIT_POS = 28;
    localparam int DST_HI = 27;
    localparam int DST_LO = 23;
    localparam int SECOND_SOURCE_OPERAND_HI = 22;
    localparam int SECOND_SOURCE_OPERAND_LO = 18;
    localparam int FIRST_SOURCE_OPERAND_HI = 17;
    localparam int FIRST_SOURCE_OPERAND_LO = 13;
    localparam int XBIT_POS = 12;
    localparam int SIDE_POS = 1;
    localparam int CST16_HI = 22;
    localparam int CST16_LO = 7;
    localparam int SCST_HI = 22;
    localparam int SCST_LO = 18;

    // ****************************************************************
    // Unit tails and opfields
    // ****************************************************************
    localparam logic [4:0] S_MVK_TAIL = 5'h0A;
    localparam logic [10:0] L_MVK_TAIL = 11'h0D6;
    localparam logic [4:0] L_MVK_OP = 5'h05;
    localparam logic [4:0] D_MVK_TAIL = 5'h10;
    localparam logic [5:0] D_MVK_OP = 6'h00;
    localparam logic [2:0] L_TAIL = 3'h6;
    localparam logic [6:0] L_OR_REG = 7'h7F;
    localparam logic [6:0] L_OR_IMM = 7'h7E;
    localparam logic [3:0] S_TAIL = 4'h8;
    localparam logic [5:0] S_OR_REG = 6'h1B;
    localparam logic [5:0] S_OR_IMM = 6'h1A;
    localparam logic [3:0] D_TAIL = 4'hC;
    localparam logic [1:0] D_PREFIX = 2'h2;
    localparam logic [3:0] D_OR_REG = 4'h1;
    localparam logic [3:0] D_OR_IMM = 4'h3;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ---- rtl/or_and_move_constant_exec.sv ----
// Decode and first-execute-stage datapath for OR and move-constant
`timescale 1ns/1ps
module or_and_move_constant_exec
    import orm_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic issue,
    input wire logic [31:0] opcode,
    input wire logic pred_true,
    input wire logic [31:0] first_source_operand,
    input wire logic [31:0] second_source_operand,
    output logic [4:0] first_source_operand_idx,
    output logic [4:0] second_source_operand_idx,
    output logic second_source_operand_cross,
    output logic [31:0] wr_data,
    output logic [4:0] wr_idx,
    output logic wr_side,
    output logic wr_en,
    output logic recognised
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic [31:0] sext5(input logic [4:0] v);
        sext5 = {{27{v[4]}}, v};
    endfunction

    wire logic mvk_s = opcode[6:2] == S_MVK_TAIL;
    // Fixed pattern in bits 12..2, unit opfield in the first source field
    wire logic mvk_l = opcode[12:2] == L_MVK_TAIL
        && opcode[FIRST_SOURCE_OPERAND_HI:FIRST_SOURCE_OPERAND_LO] == L_MVK_OP;
    wire logic mvk_d = opcode[6:2] == D_MVK_TAIL
        && opcode[12:7] == D_MVK_OP;
    wire logic or_l_reg = opcode[4:2] == L_TAIL
        && opcode[11:5] == L_OR_REG;
    wire logic or_l_imm = opcode[4:2] == L_TAIL
        && opcode[11:5] == L_OR_IMM;
    wire logic or_s_reg = opcode[5:2] == S_TAIL
        && opcode[11:6] == S_OR_REG;
    wire logic or_s_imm = opcode[5:2] == S_TAIL
        && opcode[11:6] == S_OR_IMM;
    wire logic d_ok = opcode[5:2] == D_TAIL && opcode[11:10] == D_PREFIX;
    wire logic or_d_reg = d_ok && opcode[9:6] == D_OR_REG;
    wire logic or_d_imm = d_ok && opcode[9:6] == D_OR_IMM;
    // [RULE5] [RULE6]
    wire logic is_or_reg = or_l_reg || or_s_reg || or_d_reg;
    wire logic is_or_imm = or_l_imm || or_s_imm || or_d_imm;
    wire logic is_mvk5 = mvk_l || mvk_d; // [RULE1]
    wire logic is_valid = is_or_reg || is_or_imm || is_mvk5 || mvk_s;
    wire logic [4:0] f1 = opcode[FIRST_SOURCE_OPERAND_HI:FIRST_SOURCE_OPERAND_LO];
    // [RULE4]
    wire logic [31:0] op1 = is_or_imm ? sext5(f1) : first_source_operand;
    // [RULE8] [RULE9]
    wire logic [31:0] cst16 = {{16{opcode[CST16_HI]}},
        opcode[CST16_HI:CST16_LO]};
    // Logic-unit form holds its constant in the second source field
    wire logic [4:0] cst5 = mvk_l ? opcode[SCST_HI:SCST_LO] : f1;
    wire logic [31:0] result = mvk_s ? cst16 : is_mvk5 ? sext5(cst5) :
        (op1 | second_source_operand); // [RULE3]

    assign first_source_operand_idx = f1;
    assign second_source_operand_idx = opcode[SECOND_SOURCE_OPERAND_HI:SECOND_SOURCE_OPERAND_LO];
    assign second_source_operand_cross = opcode[XBIT_POS] && (is_or_reg || is_or_imm);
    assign recognised = issue && is_valid;

    // ****************************************************************
    // First execute stage write-back
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_en <= 1'b0;
            wr_data <= RESET_WORD;
            wr_idx <= 5'h00;
            wr_side <= 1'b0;
        end else begin
            // [RULE7] [RULE2] [RULE10]
            wr_en <= issue && is_valid && pred_true;
            wr_data <= result;
            wr_idx <= opcode[DST_HI:DST_LO];
            wr_side <= opcode[SIDE_POS];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Instruction decoded and allowed to execute
    sequence s_exec;
        issue && is_valid && pred_true;
    endsequence

    // Instruction squashed by a false predicate
    sequence s_squash;
        issue && !pred_true;
    endsequence

    // Issued word that neither OR nor move-constant decodes
    sequence s_foreign;
        issue && !is_valid;
    endsequence

    // Write-back strobe in the first execute stage
    sequence s_write;
        wr_en;
    endsequence

    // No write-back strobe
    sequence s_quiet;
        !wr_en;
    endsequence

    // ****************************************************************
    // Timing and refusal
    // ****************************************************************
    AST_PRED_NOP: assert property (@(posedge mclk) disable iff (srst)
        s_squash |=> s_quiet) // [RULE10]
        else $error("write despite false predicate");

    AST_SINGLE: assert property (@(posedge mclk) disable iff (srst)
        s_exec |=> s_write) // [RULE7]
        else $error("write not in one cycle");

    AST_FOREIGN: assert property (@(posedge mclk) disable iff (srst)
        s_foreign |=> s_quiet) // [RULE6]
        else $error("write for an undecoded word");

    AST_IDLE: assert property (@(posedge mclk) disable iff (srst)
        !issue |=> s_quiet) // [RULE7]
        else $error("write without an issue");

    AST_RESET: assert property (@(posedge mclk)
        srst |=> !wr_en && wr_data == RESET_WORD) // [RULE7]
        else $error("write-back not cleared by reset");

    // ****************************************************************
    // Results
    // ****************************************************************
    AST_OR: assert property (@(posedge mclk) disable iff (srst)
        issue && is_or_reg && pred_true |=> wr_data ==
        ($past(first_source_operand) | $past(second_source_operand)))
        // [RULE3]
        else $error("OR result wrong");

    AST_IMM_HI: assert property (@(posedge mclk) disable iff (srst)
        issue && is_or_imm && pred_true |=>
        wr_data[31:5] == ({27{$past(opcode[FIRST_SOURCE_OPERAND_HI])}}
        | $past(second_source_operand[31:5]))) // [RULE4]
        else $error("immediate not sign extended");

    AST_IMM_LO: assert property (@(posedge mclk) disable iff (srst)
        issue && is_or_imm && pred_true |=>
        wr_data[4:0] == ($past(opcode[FIRST_SOURCE_OPERAND_HI:FIRST_SOURCE_OPERAND_LO])
        | $past(second_source_operand[4:0]))) // [RULE4]
        else $error("immediate low bits wrong");

    AST_MVK16: assert property (@(posedge mclk) disable iff (srst)
        issue && mvk_s && pred_true |=> wr_data ==
        {{16{$past(opcode[CST16_HI])}},
        $past(opcode[CST16_HI:CST16_LO])}) // [RULE8]
        else $error("constant not sign extended");

    AST_MVK5L: assert property (@(posedge mclk) disable iff (srst)
        issue && mvk_l && pred_true |=> wr_data ==
        {{27{$past(opcode[SCST_HI])}},
        $past(opcode[SCST_HI:SCST_LO])}) // [RULE8]
        else $error("logic-unit constant wrong");

    AST_MVK5D: assert property (@(posedge mclk) disable iff (srst)
        issue && mvk_d && pred_true |=> wr_data ==
        {{27{$past(opcode[FIRST_SOURCE_OPERAND_HI])}},
        $past(opcode[FIRST_SOURCE_OPERAND_HI:FIRST_SOURCE_OPERAND_LO])}) // [RULE1]
        else $error("data-unit constant wrong");

    // ****************************************************************
    // Destination
    // ****************************************************************
    AST_LDST: assert property (@(posedge mclk) disable iff (srst)
        s_exec |=> wr_idx == $past(opcode[DST_HI:DST_LO])) // [RULE2]
        else $error("destination index wrong");

    AST_SIDE: assert property (@(posedge mclk) disable iff (srst)
        s_exec |=> wr_side == $past(opcode[SIDE_POS])) // [RULE1]
        else $error("destination side wrong");

    // ****************************************************************
    // Operand routing
    // ****************************************************************
    AST_FIRST_SOURCE_OPERAND: assert property (@(posedge mclk) disable iff (srst)
        issue |-> first_source_operand_idx == opcode[FIRST_SOURCE_OPERAND_HI:FIRST_SOURCE_OPERAND_LO]) // [RULE7]
        else $error("first source index wrong");

    AST_SECOND_SOURCE_OPERAND: assert property (@(posedge mclk) disable iff (srst)
        issue |-> second_source_operand_idx == opcode[SECOND_SOURCE_OPERAND_HI:SECOND_SOURCE_OPERAND_LO]) // [RULE7]
        else $error("second source index wrong");

    AST_CROSS: assert property (@(posedge mclk) disable iff (srst)
        issue && !(is_or_reg || is_or_imm) |-> !second_source_operand_cross) // [RULE5]
        else $error("cross path requested outside OR");

    // ****************************************************************
    // Encodings, written out bit for bit
    // ****************************************************************
    AST_OR_L_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[4:2] == 3'h6 && (opcode[11:5] == 7'h7F
        || opcode[11:5] == 7'h7E) |-> recognised) // [RULE6]
        else $error("logic-unit OR not recognised");

    AST_OR_S_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[5:2] == 4'h8 && (opcode[11:6] == 6'h1B
        || opcode[11:6] == 6'h1A) |-> recognised) // [RULE6]
        else $error("shift-unit OR not recognised");

    AST_OR_D_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[5:2] == 4'hC && opcode[11:10] == 2'h2
        && (opcode[9:6] == 4'h1 || opcode[9:6] == 4'h3) |-> recognised)
        // [RULE6]
        else $error("data-unit OR not recognised");

    AST_MVK_S_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[6:2] == 5'h0A |-> recognised) // [RULE1]
        else $error("shift-unit constant not recognised");

    AST_MVK_L_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[12:2] == 11'h0D6 && opcode[17:13] == 5'h05
        |-> recognised) // [RULE1]
        else $error("logic-unit constant not recognised");

    AST_MVK_D_DEC: assert property (@(posedge mclk) disable iff (srst)
        issue && opcode[12:2] == 11'h010 |-> recognised) // [RULE1]
        else $error("data-unit constant not recognised");

    AST_NO_ISSUE: assert property (@(posedge mclk) disable iff (srst)
        !issue |-> !recognised) // [RULE6]
        else $error("recognised without an issue");

endmodule // or_and_move_constant_exec

// ---- dv/regfile_model.sv ----
// Register file model feeding operands and taking write-backs
`timescale 1ns/1ps
module regfile_model (
    input wire logic mclk,
    input wire logic side,
    input wire logic [4:0] first_source_operand_idx,
    input wire logic [4:0] second_source_operand_idx,
    input wire logic second_source_operand_cross,
    input wire logic [31:0] wr_data,
    input wire logic [4:0] wr_idx,
    input wire logic wr_side,
    input wire logic wr_en,
    output logic [31:0] first_source_operand,
    output logic [31:0] second_source_operand
);
    logic [31:0] rf [2][32];
    function automatic logic [31:0] rd(input logic s, input logic [4:0] i);
        // Bypass the write in flight so the next issue sees it
        if (wr_en && wr_side == s && wr_idx == i) return wr_data;
        return rf[s][i];
    endfunction
    initial for (int k = 0; k < 64; k++) rf[k/32][k%32] = 32'h0F1E_2D3C * k;
    always_comb first_source_operand = rd(side, first_source_operand_idx);
    always_comb second_source_operand = rd(side ^ second_source_operand_cross, second_source_operand_idx);
    always @(posedge mclk) if (wr_en) rf[wr_side][wr_idx] <= wr_data;
endmodule // regfile_model

// ---- dv/or_and_move_constant_exec_tb_top.sv ----
// Self-checking bench for the OR / move-constant execute slice
`timescale 1ns/1ps
module or_and_move_constant_exec_tb_top;
    import orm_pkg::*;
    logic mclk = 0, srst = 1, issue = 0, pred_true = 1, side = 0;
    logic [31:0] opcode = 32'h0000_0000;
    logic [31:0] op1, op2, wr_data;
    logic [4:0] first_source_operand_idx, second_source_operand_idx, wr_idx;
    logic second_source_operand_cross, wr_side, wr_en, recognised;
    int n_errors = 0, n_checks = 0, cyc = 0;
    or_and_move_constant_exec u_dut (.mclk(mclk), .srst(srst), .issue(issue),
        .opcode(opcode), .pred_true(pred_true), .first_source_operand(op1),
        .second_source_operand(op2), .first_source_operand_idx(first_source_operand_idx),
        .second_source_operand_idx(second_source_operand_idx), .second_source_operand_cross(second_source_operand_cross), .wr_data(wr_data),
        .wr_idx(wr_idx), .wr_side(wr_side), .wr_en(wr_en),
        .recognised(recognised));
    regfile_model u_rf (.mclk(mclk), .side(side), .first_source_operand_idx(first_source_operand_idx),
        .second_source_operand_idx(second_source_operand_idx), .second_source_operand_cross(second_source_operand_cross), .wr_data(wr_data),
        .wr_idx(wr_idx), .wr_side(wr_side), .wr_en(wr_en),
        .first_source_operand(op1), .second_source_operand(op2));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic run(logic [31:0] w, logic s, logic p, logic [31:0] e);
        @(negedge mclk);
        opcode = w;
        side = s;
        pred_true = p;
        issue = 1;
        #1 chk("recognised", 1, recognised);
        @(negedge mclk);
        issue = 0;
        chk("wr_en", p, wr_en);
        if (p) begin
            chk("wr_data", e, wr_data);
            chk("wr_dst", {s, w[27:23]}, {wr_side, wr_idx});
        end
    endtask
    task automatic t_or(int u, logic i, logic x, logic s, logic [4:0] d,
                        logic [4:0] f2, logic [4:0] f1);
        logic [31:0] w;
        logic [31:0] a;
        a = i ? {{27{f1[4]}}, f1} : u_rf.rd(s, f1);
        case (u)
            0: w = {4'h0, d, f2, f1, x, i ? L_OR_IMM : L_OR_REG, L_TAIL, s, 1'h0};
            1: w = {4'h0, d, f2, f1, x, i ? S_OR_IMM : S_OR_REG, S_TAIL, s, 1'h0};
            default: w = {4'h0, d, f2, f1, x, D_PREFIX,
                          i ? D_OR_IMM : D_OR_REG, D_TAIL, s, 1'h0};
        endcase
        run(w, s, 1, a | u_rf.rd(s ^ x, f2));
    endtask
    task automatic t_mvk(int u, logic s, logic [4:0] d, logic [15:0] c, logic p);
        logic [31:0] w;
        case (u)
            0: w = {4'h0, d, c[4:0], L_MVK_OP, L_MVK_TAIL, s, 1'h0};
            1: w = {4'h0, d, c, S_MVK_TAIL, s, 1'h0};
            default: w = {4'h0, d, 5'h00, c[4:0], D_MVK_OP, D_MVK_TAIL, s, 1'h0};
        endcase
        run(w, s, p, u == 1 ? {{16{c[15]}}, c} : {{27{c[4]}}, c[4:0]});
    endtask
    task automatic t_bad(logic [31:0] w);
        @(negedge mclk);
        opcode = w;
        pred_true = 1;
        issue = 1;
        #1 chk("recognised", 0, recognised);
        @(negedge mclk);
        issue = 0;
        chk("wr_en", 0, wr_en);
    endtask
    task automatic t_b2b();
        logic [31:0] e;
        e = 32'hFFFF_C678 | u_rf.rd(0, 5'h09);
        @(negedge mclk);
        opcode = {4'h0, 5'h08, 16'hC678, S_MVK_TAIL, 2'h0};
        side = 0;
        issue = 1;
        @(negedge mclk);
        chk("wr_data", 32'hFFFF_C678, wr_data);
        opcode = {4'h0, 5'h0A, 5'h09, 5'h08, 1'h0, S_OR_REG, S_TAIL, 2'h0};
        @(negedge mclk);
        issue = 0;
        chk("wr_data", e, wr_data);
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        srst = 0;
        for (int u = 0; u < 3; u++) begin
            t_mvk(u, u[0], 5'h03, 16'hFFFB, 1);
            t_mvk(u, 0, 5'h04, 16'h000F, 1);
            t_mvk(u, 1, 5'h05, 16'h0007, 0);
            t_or(u, 0, 0, u[0], 5'h06, 5'h0B, 5'h0C);
            t_or(u, 1, 1, 0, 5'h07, 5'h0D, 5'h14);
        end
        t_mvk(1, 0, 5'h08, 16'h5678, 1);
        t_b2b();
        t_bad(32'h0000_0000);
        t_bad({9'h000, 10'h021, 6'h00, 7'h7D, L_TAIL, 2'h0});
        report_and_stop();
    end
endmodule // or_and_move_constant_exec_tb_top
